// >>> include/sorint_cfg.svh
// Purpose: Timing constants and reset values for the restart interlock
// Assumes: 50 MHz system clock
// Notes: Debounce time is given in microseconds and converted to cycles
`ifndef SORINT_CFG_SVH
`define SORINT_CFG_SVH
`define SORINT_CLK_HZ 50000000
`define SORINT_DEBOUNCE_US 10000
`define SORINT_DEBOUNCE_CYC ((`SORINT_DEBOUNCE_US * (`SORINT_CLK_HZ / 1000000)))
`define SORINT_OUT_RST 1'b0
`endif

// >>> include/sorint_pkg.sv
// Purpose: Types for the restart interlock
// Assumes: One clock, one reset
// Notes: State codes are one-hot
package sorint_pkg;
   typedef enum logic [3:0] {
      SORINT_ST_OFF = 4'b0001,
      SORINT_ST_WAIT_PRESS = 4'b0010,
      SORINT_ST_WAIT_REL = 4'b0100,
      SORINT_ST_ON = 4'b1000
   } sorint_state_t;
endpackage : sorint_pkg

// >>> rtl/sorint_debounce.sv
// Purpose: Two-flop synchroniser followed by a stability debouncer
// Assumes: Input is asynchronous to clk_sys
// Notes: Output changes only after the input holds steady for STABLE_CYC cycles
module sorint_debounce #(
   parameter int unsigned STABLE_CYC = 500000
) (
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic pin_in, // Raw pin level
   output logic level_out // Clean level
);
   localparam int unsigned CW = $clog2(STABLE_CYC + 1);
   logic meta_r, sync_r, level_r, level_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;

   // Counter clears whenever the synchronised input agrees with the held level
   always_comb begin
      level_nxt = level_r;
      cnt_nxt = '0;
      if (sync_r != level_r) begin
         if (cnt_r == CW'(STABLE_CYC - 1)) begin
            level_nxt = sync_r;
         end else begin
            cnt_nxt = cnt_r + CW'(1);
         end
      end
   end

   // First flop feeds only the second
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         level_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         level_r <= level_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign level_out = level_r;
endmodule : sorint_debounce

// >>> rtl/sorint_interlock.sv
// Purpose: Restart interlock driving two solid-state safety outputs
// Assumes: field_clear and lockout come from logic on clk_sys
// Notes: Outputs default off; any doubt keeps them off
// Behaviour
// - Both safety outputs go off as soon as the field is interrupted.
// - After each interruption the feedback loop must read closed before outputs return.
// - A restart mode input selects automatic or manual restart.
// - In automatic mode outputs return at once when the field clears and the loop is closed.
// - In manual mode outputs stay off until the button is pressed then released, loop closed.
// - An open feedback loop keeps outputs off and refuses every restart.
// - A restart is ignored during lockout or while the field is still interrupted.
`include "sorint_cfg.svh"
module sorint_interlock
   import sorint_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYC = `SORINT_DEBOUNCE_CYC
) (
   input wire logic clk_sys, // System clock, 50 MHz
   input wire logic resetn, // Async reset, active low
   input wire logic field_clear, // High while no beam is broken
   input wire logic lockout, // High during failure or interference lockout
   input wire logic manual_mode, // High selects manual restart
   input wire logic restart_pin, // Restart button, high while held
   input wire logic contactor_feedback_loop, // High when contactor loop closed
   output logic safety_out_a, // First safety output
   output logic safety_out_b, // Second safety output
   output logic restart_wait // High while waiting for a button restart
);
   logic restart_lvl, loop_lvl;
   logic press_seen_r, press_seen_nxt;
   logic out_r, out_nxt, wait_r, wait_nxt;
   sorint_state_t state_r, state_nxt;
   logic ok_to_run;

   // Debounce both contacts; button is normally open so high means pressed
   sorint_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_restart_db (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_in(restart_pin),
      .level_out(restart_lvl)
   );
   sorint_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_loop_db (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_in(contactor_feedback_loop),
      .level_out(loop_lvl)
   );

   // Common gate for any return to on
   assign ok_to_run = field_clear && !lockout && loop_lvl;

   // Restart sequencer; a press that starts before waiting is not counted
   always_comb begin
      state_nxt = state_r;
      press_seen_nxt = press_seen_r;
      unique case (state_r)
         SORINT_ST_ON: begin
            if (!field_clear || lockout) begin
               state_nxt = SORINT_ST_OFF;
            end
         end
         SORINT_ST_OFF: begin
            press_seen_nxt = 1'b0;
            if (ok_to_run) begin
               if (manual_mode) begin
                  state_nxt = SORINT_ST_WAIT_PRESS;
               end else begin
                  state_nxt = SORINT_ST_ON;
               end
            end
         end
         SORINT_ST_WAIT_PRESS: begin
            if (!ok_to_run) begin
               state_nxt = SORINT_ST_OFF;
            end else if (!manual_mode) begin
               state_nxt = SORINT_ST_ON;
            end else if (!restart_lvl) begin
               // Button must be seen released first so a stuck button cannot restart
               state_nxt = SORINT_ST_WAIT_REL;
            end
         end
         SORINT_ST_WAIT_REL: begin
            if (!ok_to_run) begin
               state_nxt = SORINT_ST_OFF;
            end else if (restart_lvl) begin
               press_seen_nxt = 1'b1;
            end else if (press_seen_r) begin
               state_nxt = SORINT_ST_ON;
            end
         end
      endcase
   end

   // Outputs registered from next state so off follows the cause by one edge
   always_comb begin
      out_nxt = (state_nxt == SORINT_ST_ON);
      wait_nxt = (state_nxt == SORINT_ST_WAIT_REL) || (state_nxt == SORINT_ST_WAIT_PRESS);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= SORINT_ST_OFF;
         press_seen_r <= 1'b0;
         out_r <= `SORINT_OUT_RST;
         wait_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         press_seen_r <= press_seen_nxt;
         out_r <= out_nxt;
         wait_r <= wait_nxt;
      end
   end

   // Two separate flops would be preferable in silicon; one keeps them identical here
   assign safety_out_a = out_r;
   assign safety_out_b = out_r;
   assign restart_wait = wait_r;
endmodule : sorint_interlock

// >>> tb/sorint_interlock_asserts.sv
// Purpose: Port checks on the restart interlock
// Assumes: Bench holds input levels steady
// Notes: Outputs lag their cause by one clock; checks allow two
module sorint_chk #(
   parameter int unsigned DEBOUNCE_CYC = 4
) (
   input wire logic clk_sys, // Clock
   input wire logic resetn, // Reset
   input wire logic field_clear, // Field
   input wire logic lockout, // Lockout
   input wire logic manual_mode, // Mode
   input wire logic restart_pin, // Button
   input wire logic contactor_feedback_loop, // Loop
   input wire logic safety_out_a, // Out a
   input wire logic safety_out_b, // Out b
   input wire logic restart_wait // Waiting
);
   // One domain, so one clocking and one disable
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   blk_off_a: assert property (!field_clear |-> ##2 !safety_out_a)
      else $error("on while blocked");
   lock_off_a: assert property (lockout |-> ##2 !safety_out_b)
      else $error("on in lockout");
   pair_same_a: assert property (safety_out_a == safety_out_b)
      else $error("outputs differ");
   loop_shut_a: assert property ($rose(safety_out_a) |-> $past(contactor_feedback_loop))
      else $error("on with loop open");
   field_rise_a: assert property ($rose(safety_out_a) |-> $past(field_clear) && !$past(lockout))
      else $error("bad restart");
   man_wait_a: assert property ($rose(safety_out_a) && manual_mode |-> $past(restart_wait))
      else $error("no wait");
   btn_up_a: assert property ($rose(safety_out_a) && manual_mode |-> !$past(restart_pin, 2))
      else $error("button held");
   wait_drop_a: assert property (restart_wait && !field_clear |-> ##2 !restart_wait)
      else $error("wait kept");
endmodule : sorint_chk
bind sorint_interlock sorint_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) sorint_chk_inst (.*);

// >>> tb/sorint_plant.sv
// Purpose: Contactor pair and restart button model
// Assumes: Contactors follow the outputs a clock late
// Notes: Weld keeps the loop open like a stuck contact
module sorint_plant (
   input wire logic clk_sys, // Clock
   input wire logic safety_out_a, // Out a
   input wire logic safety_out_b, // Out b
   input wire logic weld, // Stuck
   input wire logic press, // Hand
   output logic contactor_feedback_loop, // Loop
   output logic restart_pin // Button
);
   logic pull_r = 1'b0;
   // Coils pull in late, so the loop opens after the outputs
   always @(posedge clk_sys) pull_r <= safety_out_a | safety_out_b;
   assign contactor_feedback_loop = !pull_r && !weld;
   assign restart_pin = press; // Normally open, high only while held
endmodule : sorint_plant

// >>> tb/sorint_interlock_tb.sv
// Purpose: Self-checking bench for the restart interlock
// Assumes: Short debounce; inputs move on falling edges
// Notes: Waits of 20 clocks cover sync plus debounce
module sorint_interlock_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, resetn = 1'b0, field_clear = 1'b0, lockout = 1'b0;
   logic manual_mode = 1'b0, weld = 1'b0, press = 1'b0, contactor_feedback_loop;
   logic restart_pin, safety_out_a, safety_out_b, restart_wait;
   int failures = 0, n_checks = 0, cyc = 0;
   sorint_interlock #(.DEBOUNCE_CYC(4)) sorint_interlock_inst (.*);
   sorint_plant sorint_plant_inst (.*);
   // Clock and hang guard
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 3000) begin
      failures++;
      finish_test();
   end
   task automatic chk(string nm, logic seen, logic exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s exp %b seen %b", nm, exp, seen);
      end
   endtask : chk
   task automatic step(int n);
      repeat (n) @(negedge clk_sys);
   endtask : step
   task automatic push();
      press = 1'b1;
      step(20);
      press = 1'b0;
      step(20);
   endtask : push
   task automatic finish_test();
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // Automatic mode: on, drop, back on once the loop recloses
   task automatic t_auto();
      field_clear = 1'b1;
      step(20);
      chk("auto on", safety_out_a, 1'b1);
      field_clear = 1'b0;
      step(3);
      chk("drop", safety_out_b, 1'b0);
      field_clear = 1'b1;
      step(20);
      chk("reclose", safety_out_a, 1'b1);
   endtask : t_auto
   // Stuck contact refuses restart until freed
   task automatic t_weld();
      field_clear = 1'b0;
      weld = 1'b1;
      step(20);
      field_clear = 1'b1;
      step(20);
      chk("weld", safety_out_a, 1'b0);
      weld = 1'b0;
      step(20);
      chk("freed", safety_out_a, 1'b1);
   endtask : t_weld
   // Manual: press alone is not enough, release restarts
   task automatic t_man();
      field_clear = 1'b0;
      manual_mode = 1'b1;
      step(20);
      field_clear = 1'b1;
      step(20);
      chk("wait", restart_wait, 1'b1);
      press = 1'b1;
      step(20);
      chk("held", safety_out_a, 1'b0);
      press = 1'b0;
      step(20);
      chk("released", safety_out_a, 1'b1);
   endtask : t_man
   // Button ignored while blocked or in lockout
   task automatic t_refuse();
      field_clear = 1'b0;
      push();
      chk("blocked", safety_out_a, 1'b0);
      field_clear = 1'b1;
      lockout = 1'b1;
      push();
      chk("locked", safety_out_a, 1'b0);
      lockout = 1'b0;
      step(20);
      push();
      chk("after lock", safety_out_a, 1'b1);
      lockout = 1'b1;
      step(3);
      chk("lock drop", safety_out_b, 1'b0);
      lockout = 1'b0;
      step(20);
   endtask : t_refuse
   initial begin
      step(16);
      resetn = 1'b1;
      t_auto();
      t_weld();
      t_man();
      t_refuse();
      finish_test();
   end
endmodule : sorint_interlock_tb
